/* logic/ddc_top.sv */
// two-channel nco, mixer and half-band decimation chain
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each oscillator keeps its own 12-bit phase offset
// - accumulator loads phase offset on every reset
// - accumulator adds tuning word each clock in variable and test modes, wrapping
// - toggling sync bit 4 resets all accumulators
// - enabled sysref event resets all accumulators
// - real input uses two multipliers for i/q
// - complex input uses full complex multiply
// - control bit 7 picks real or complex input
// - filters take mixer output
// - final stage always on, others bypassable
// - control bits 1:0 pick decimation ratio
// - stage count gives ratio 2..16 or 1..8
// - tuning word is two's complement, wraps naturally
// - bits 5:4 pick variable, zero, fs/4, test
// - test mode forces input near full scale
// - complex-to-real skips final decimation
module ddc_top (
  input  wire logic                       clk_sys_i,   // sample clock
  input  wire logic                       reset_n_i,   // sync reset, active low
  input  wire logic                       reg_wr_i,    // register write strobe
  input  wire logic [11:0]                reg_addr_i,  // register address
  input  wire logic [7:0]                 reg_wdata_i, // register write data
  output logic      [7:0]                 reg_rdata_o, // read data, one cycle late
  input  wire logic                       sysref_i,    // sysref level
  input  wire logic [11:0]                smp_i_i,     // adc sample, i or real
  input  wire logic [11:0]                smp_q_i,     // adc sample, q
  output logic      [1:0]                 out_valid_o, // per-channel output strobe
  output ddc_pkg::ddc_iq_s                out_iq_o [2] // per-channel output sample
);
  localparam int NCH = ddc_pkg::NUM_CH;
  localparam int NHB = ddc_pkg::NUM_HB;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  // coarse 16-point sine, q11; enough to exercise the datapath
  function automatic logic signed [11:0] nco_sin(input logic [3:0] idx);
    logic [10:0] m;
    m = 11'h000;
    unique case (idx[2:0])
      3'h0: m = 11'h000;
      3'h1: m = 11'h30f;
      3'h2: m = 11'h5a7;
      3'h3: m = 11'h763;
      3'h4: m = 11'h7ff;
      3'h5: m = 11'h763;
      3'h6: m = 11'h5a7;
      3'h7: m = 11'h30f;
    endcase
    return idx[3] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  function automatic logic signed [15:0] half_sum(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    return s[16:1];
  endfunction

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [7:0]  sync_ctl_r;
  logic [7:0]  sysref_ctl_r;
  logic [7:0]  chan_ctl_r [NCH];
  logic [11:0] ftw_r      [NCH];
  logic [11:0] pow_r      [NCH];
  logic [11:0] acc_r      [NCH];
  logic [11:0] base_w     [NCH];

  assign base_w[0] = ddc_pkg::CH0_CTL_ADDR;
  assign base_w[1] = ddc_pkg::CH1_CTL_ADDR;

  // software writes; tuning takes effect at once, offset only at the next sync, order is software's job
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync_ctl_r   <= ddc_pkg::REG_RESET;
      sysref_ctl_r <= ddc_pkg::REG_RESET;
      for (int c = 0; c < NCH; c++) begin
        chan_ctl_r[c] <= ddc_pkg::REG_RESET;
        ftw_r[c]      <= 12'h000;
        pow_r[c]      <= 12'h000;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == ddc_pkg::SYNC_CTL_ADDR) sync_ctl_r <= reg_wdata_i;
      if (reg_addr_i == ddc_pkg::SYSREF_CTL_ADDR) sysref_ctl_r <= reg_wdata_i;
      for (int c = 0; c < NCH; c++) begin
        if (reg_addr_i == base_w[c]) chan_ctl_r[c] <= reg_wdata_i;
        if (reg_addr_i == base_w[c] + ddc_pkg::FTW_LO_OFS) ftw_r[c][7:0] <= reg_wdata_i;
        if (reg_addr_i == base_w[c] + ddc_pkg::FTW_HI_OFS) ftw_r[c][11:8] <= reg_wdata_i[3:0];
        if (reg_addr_i == base_w[c] + ddc_pkg::POW_LO_OFS) pow_r[c][7:0] <= reg_wdata_i;
        if (reg_addr_i == base_w[c] + ddc_pkg::POW_HI_OFS) pow_r[c][11:8] <= reg_wdata_i[3:0];
      end
    end
  end

  // registered read; unmapped addresses read zero
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= 8'h00;
      if (reg_addr_i == ddc_pkg::SYNC_CTL_ADDR) reg_rdata_o <= sync_ctl_r;
      if (reg_addr_i == ddc_pkg::SYSREF_CTL_ADDR) reg_rdata_o <= sysref_ctl_r;
      for (int c = 0; c < NCH; c++) begin
        if (reg_addr_i == base_w[c]) reg_rdata_o <= chan_ctl_r[c];
        if (reg_addr_i == base_w[c] + ddc_pkg::FTW_LO_OFS) reg_rdata_o <= ftw_r[c][7:0];
        if (reg_addr_i == base_w[c] + ddc_pkg::FTW_HI_OFS) reg_rdata_o <= {4'h0, ftw_r[c][11:8]};
        if (reg_addr_i == base_w[c] + ddc_pkg::POW_LO_OFS) reg_rdata_o <= pow_r[c][7:0];
        if (reg_addr_i == base_w[c] + ddc_pkg::POW_HI_OFS) reg_rdata_o <= {4'h0, pow_r[c][11:8]};
        if (reg_addr_i == base_w[c] + ddc_pkg::ACC_RD_OFS) reg_rdata_o <= acc_r[c][11:4];
      end
    end
  end

  // ------------------------------------------------------------------
  // oscillator synchronisation
  // ------------------------------------------------------------------
  logic soft_prev_r;
  logic sysref_prev_r;
  logic soft_hit;
  logic sysref_hit;
  logic sync_hit;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      soft_prev_r   <= 1'b0;
      sysref_prev_r <= 1'b0;
    end else begin
      soft_prev_r   <= sync_ctl_r[ddc_pkg::SYNC_SOFT_BIT];
      sysref_prev_r <= sysref_i;
    end
  end

  // either edge of the soft bit counts, so a 0-1-0 toggle syncs twice harmlessly
  assign soft_hit   = soft_prev_r != sync_ctl_r[ddc_pkg::SYNC_SOFT_BIT];
  assign sysref_hit = sysref_i && !sysref_prev_r && sysref_ctl_r[ddc_pkg::SYSREF_EN_BIT]
                      && (|sync_ctl_r[ddc_pkg::SYNC_EN_LSB +: 2]);
  assign sync_hit   = soft_hit || sysref_hit;

  // ------------------------------------------------------------------
  // phase accumulators
  // ------------------------------------------------------------------
  ddc_pkg::ddc_if_mode_e mode_w [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      mode_w[c] = ddc_pkg::ddc_if_mode_e'(chan_ctl_r[c][ddc_pkg::CTL_MODE_LSB +: 2]);
    end
  end

  // two's complement tuning word wraps modulo 2^12 on its own
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!reset_n_i) begin
        acc_r[c] <= 12'h000;
      end else if (sync_hit) begin
        acc_r[c] <= pow_r[c];
      end else if (mode_w[c] == ddc_pkg::IF_FS4) begin
        acc_r[c] <= acc_r[c] + ddc_pkg::FS4_STEP;
      end else if (mode_w[c] != ddc_pkg::IF_ZERO) begin
        acc_r[c] <= acc_r[c] + ftw_r[c];
      end
    end
  end

  // ------------------------------------------------------------------
  // mixer
  // ------------------------------------------------------------------
  logic signed [11:0] mx_xi [NCH];
  logic signed [11:0] mx_xq [NCH];
  ddc_pkg::ddc_iq_s   mix_nxt [NCH];
  ddc_pkg::ddc_iq_s   mix_r   [NCH];
  logic               mix_v_r;

  always_comb begin
    logic signed [11:0] cs;
    logic signed [11:0] sn;
    logic signed [24:0] pi;
    logic signed [24:0] pq;
    cs = 12'sh000;
    sn = 12'sh000;
    pi = 25'sh0000000;
    pq = 25'sh0000000;
    for (int c = 0; c < NCH; c++) begin
      mx_xi[c] = (mode_w[c] == ddc_pkg::IF_TEST) ? ddc_pkg::TEST_LEVEL : smp_i_i;
      mx_xq[c] = (mode_w[c] == ddc_pkg::IF_TEST || !chan_ctl_r[c][ddc_pkg::CTL_CPLX_BIT])
                 ? 12'sh000 : smp_q_i;
      sn = nco_sin(acc_r[c][11:8]);
      cs = nco_sin(acc_r[c][11:8] + ddc_pkg::QUARTER);
      if (chan_ctl_r[c][ddc_pkg::CTL_CPLX_BIT] && mode_w[c] != ddc_pkg::IF_TEST) begin
        // full complex multiply, halved to keep headroom
        pi = (25'(mx_xi[c] * cs) + 25'(mx_xq[c] * sn)) >>> 1;
        pq = (25'(mx_xq[c] * cs) - 25'(mx_xi[c] * sn)) >>> 1;
      end else begin
        pi = 25'(mx_xi[c] * cs);
        pq = -25'(mx_xi[c] * sn);
      end
      if (mode_w[c] == ddc_pkg::IF_ZERO) begin
        mix_nxt[c].i = {mx_xi[c], 4'h0};
        mix_nxt[c].q = {mx_xq[c], 4'h0};
      end else begin
        mix_nxt[c].i = pi[22:7];
        mix_nxt[c].q = pq[22:7];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mix_v_r <= 1'b0;
      for (int c = 0; c < NCH; c++) mix_r[c] <= '0;
    end else begin
      mix_v_r <= 1'b1;
      for (int c = 0; c < NCH; c++) mix_r[c] <= mix_nxt[c];
    end
  end

  // ------------------------------------------------------------------
  // half-band chain: index 0 first stage .. 3 final stage
  // ------------------------------------------------------------------
  ddc_pkg::ddc_iq_s st_d [NCH][NHB+1];
  logic             st_v [NCH][NHB+1];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign st_d[c][0] = mix_r[c];
    assign st_v[c][0] = mix_v_r;
    for (genvar k = 0; k < NHB; k++) begin : g_hb
      ddc_pkg::ddc_iq_s hold_r;
      ddc_pkg::ddc_iq_s sum_w;
      logic             ph_r;
      logic             en_w;
      logic             c2r_w;
      logic [1:0]       ratio_w;
      assign ratio_w = chan_ctl_r[c][ddc_pkg::CTL_RATIO_LSB +: 2];
      assign c2r_w   = chan_ctl_r[c][ddc_pkg::CTL_C2R_BIT];
      // stage k runs when ratio reaches NHB-1-k; final stage always
      assign en_w    = (k == NHB - 1) || (32'(ratio_w) >= NHB - 1 - k);
      assign sum_w.i = half_sum(hold_r.i, st_d[c][k].i);
      assign sum_w.q = (k == NHB - 1 && c2r_w) ? 16'sh0000 : half_sum(hold_r.q, st_d[c][k].q);
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
          hold_r        <= '0;
          ph_r          <= 1'b0;
          st_d[c][k+1]  <= '0;
          st_v[c][k+1]  <= 1'b0;
        end else begin
          st_v[c][k+1] <= 1'b0;
          if (st_v[c][k] && !en_w) begin
            st_d[c][k+1] <= st_d[c][k];
            st_v[c][k+1] <= 1'b1;
          end else if (st_v[c][k]) begin
            hold_r <= st_d[c][k];
            ph_r   <= !ph_r;
            if (ph_r || (k == NHB - 1 && c2r_w)) begin
              st_d[c][k+1] <= sum_w;
              st_v[c][k+1] <= 1'b1;
            end
          end
        end
      end
    end
    assign out_iq_o[c]    = st_d[c][NHB];
    assign out_valid_o[c] = st_v[c][NHB];
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_acc_advance: assert property (!sync_hit && mode_w[0] == ddc_pkg::IF_VAR
    |=> acc_r[0] == 12'($past(acc_r[0]) + $past(ftw_r[0])))
    else $error("accumulator did not advance by tuning word");
  a_acc_load: assert property (sync_hit |=> acc_r[1] == $past(pow_r[1]))
    else $error("accumulator not loaded with phase offset");
  a_soft_sync: assert property ($changed(sync_ctl_r[4]) |=> $past(sync_hit) && acc_r[0] == $past(pow_r[0]))
    else $error("soft reset toggle did not sync");
  a_sysref_gate: assert property ($rose(sysref_i) && !sysref_ctl_r[1] && !soft_hit |-> !sync_hit)
    else $error("sysref synced while disabled");
  a_test_force: assert property (mode_w[0] == ddc_pkg::IF_TEST |-> mx_xi[0] == ddc_pkg::TEST_LEVEL)
    else $error("test mode input not forced");
  a_zif_pass: assert property (mode_w[0] == ddc_pkg::IF_ZERO |=> mix_r[0].i == {$past(smp_i_i), 4'h0})
    else $error("zero if did not bypass mixer");
  a_bypass_pass: assert property (st_v[0][1] && chan_ctl_r[0][1:0] == 2'b00
    |=> st_v[0][2] && st_d[0][2] == $past(st_d[0][1]))
    else $error("bypassed stage altered sample");
  a_final_decim: assert property (out_valid_o[0] && !chan_ctl_r[0][3] && $stable(chan_ctl_r[0])
    |=> !out_valid_o[0])
    else $error("final stage did not decimate");
  a_real_noq: assert property (out_valid_o[1] && $past(chan_ctl_r[1][3]) |-> out_iq_o[1].q == 16'sh0000)
    else $error("real output carries q");

  c_sysref_sync: cover property (sysref_hit);
  c_full_decim: cover property (chan_ctl_r[0][1:0] == 2'b11 && out_valid_o[0]);
  c_c2r_out: cover property (chan_ctl_r[1][3] && out_valid_o[1]);
endmodule

`default_nettype wire

/* common/ddc_pkg.sv */
// shared constants and types for the downconverter channel logic
package ddc_pkg;
  // ----------------------------------------------------------------
  // register map (spi byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] SYSREF_CTL_ADDR = 12'h120;
  localparam logic [11:0] SYNC_CTL_ADDR   = 12'h300;
  localparam logic [11:0] CH0_CTL_ADDR    = 12'h310;
  localparam logic [11:0] CH1_CTL_ADDR    = 12'h330;
  localparam logic [11:0] FTW_LO_OFS      = 12'h004; // from channel control address
  localparam logic [11:0] FTW_HI_OFS      = 12'h005;
  localparam logic [11:0] POW_LO_OFS      = 12'h006;
  localparam logic [11:0] POW_HI_OFS      = 12'h007;
  localparam logic [11:0] ACC_RD_OFS      = 12'h008; // phase accumulator bits 11:4
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SYNC_SOFT_BIT  = 4;
  localparam int SYNC_EN_LSB    = 0;
  localparam int SYSREF_EN_BIT  = 1;
  localparam int CTL_CPLX_BIT   = 7;
  localparam int CTL_MODE_LSB   = 4;
  localparam int CTL_C2R_BIT    = 3;
  localparam int CTL_RATIO_LSB  = 0;
  // ----------------------------------------------------------------
  // datapath constants
  // ----------------------------------------------------------------
  localparam int              NCO_W      = 12;
  localparam int              SMP_W      = 12;
  localparam int              OUT_W      = 16;
  localparam int              NUM_CH     = 2;
  localparam int              NUM_HB     = 4;
  localparam logic [11:0]     FS4_STEP   = 12'h400;
  localparam logic [11:0]     TEST_LEVEL = 12'h7fe; // 0.999 of positive full scale
  localparam logic [3:0]      QUARTER    = 4'h4;

  typedef enum logic [1:0] {
    IF_VAR  = 2'b00,
    IF_ZERO = 2'b01,
    IF_FS4  = 2'b10,
    IF_TEST = 2'b11
  } ddc_if_mode_e;

  typedef struct packed {
    logic signed [OUT_W-1:0] i;
    logic signed [OUT_W-1:0] q;
  } ddc_iq_s;
endpackage

/* bench/ddc_adc_model.sv */
// converter sample source feeding the downconverter input
`timescale 1ns/1ps
`default_nettype none
module ddc_adc_model (
  input  wire logic        clk_i,   // sample clock
  input  wire logic [11:0] lvl_i_i, // requested real or i level
  input  wire logic [11:0] lvl_q_i, // requested q level
  output logic      [11:0] smp_i_o, // real or i sample
  output logic      [11:0] smp_q_o  // q sample
);
  // ------------------------------------------------------------
  // sample launch
  // ------------------------------------------------------------
  // known level before the first edge so the mixer never sees x
  initial begin
    smp_i_o = 12'h000;
    smp_q_o = 12'h000;
  end
  // new sample just after each edge, one per clock like the core
  always @(posedge clk_i) begin
    smp_i_o <= #1 lvl_i_i;
    smp_q_o <= #1 lvl_q_i;
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the two downconverter channels
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  localparam logic [11:0] C0 = ddc_pkg::CH0_CTL_ADDR;
  localparam logic [11:0] C1 = ddc_pkg::CH1_CTL_ADDR;
  localparam logic [11:0] SY = ddc_pkg::SYNC_CTL_ADDR;
  logic             clk_sys_i   = 1'b0;
  logic             reset_n_i   = 1'b0;
  logic             reg_wr_i    = 1'b0;
  logic [11:0]      reg_addr_i  = 12'h000;
  logic [7:0]       reg_wdata_i = 8'h00;
  logic             sysref_i    = 1'b0;
  logic [11:0]      lvl_i       = 12'h000;
  logic [11:0]      lvl_q       = 12'h000;
  logic [11:0]      smp_i_i;
  logic [11:0]      smp_q_i;
  logic [7:0]       reg_rdata_o;
  logic [1:0]       out_valid_o;
  ddc_pkg::ddc_iq_s out_iq_o [2];
  logic [31:0]      exp_q [$];
  logic [31:0]      e;
  logic [31:0]      o;
  logic [11:0]      acc;
  logic [11:0]      pw;
  logic             rd_chk   = 1'b0;
  logic             sync_bit = 1'b0;
  int               err_total = 0;
  int               checked   = 0;
  int               kind      = 0; // 0 idle, 1 read data, 2 strobe gap, 3 sample
  int               ch        = 0;
  int               gap       = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  ddc_adc_model adc (.clk_i(clk_sys_i), .lvl_i_i(lvl_i), .lvl_q_i(lvl_q),
                     .smp_i_o(smp_i_i), .smp_q_o(smp_q_i));
  ddc_top uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
               .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
               .reg_rdata_o(reg_rdata_o), .sysref_i(sysref_i), .smp_i_i(smp_i_i),
               .smp_q_i(smp_q_i), .out_valid_o(out_valid_o), .out_iq_o(out_iq_o));

  // ------------------------------------------------------------
  // scoreboard
  // ------------------------------------------------------------
  // mid-cycle sampling keeps clear of the edge that launches outputs
  always @(negedge clk_sys_i) begin
    gap <= out_valid_o[ch] ? 1 : gap + 1;
    if (exp_q.size() > 0 && (kind == 1 ? rd_chk : (kind > 1 && out_valid_o[ch]))) begin
      e = exp_q.pop_front();
      case (kind)
        1: o = {24'h0, reg_rdata_o};
        2: o = gap;
        default: o = out_iq_o[ch];
      endcase
      `CHK(o, e)
    end
  end

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("counts: %0d compared, %0d wrong", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_sys_i) #1;
    reg_wr_i = 1'b0;
  endtask
  // 12-bit words go low byte then high byte, each lands alone
  task automatic wr12(input logic [11:0] a, input logic [11:0] v);
    wr(a, v[7:0]);
    wr(a + 12'h001, {4'h0, v[11:8]});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    kind = 1;
    @(posedge clk_sys_i) #1;
    reg_addr_i = a;
    exp_q.push_back({24'h0, x});
    @(posedge clk_sys_i) #1;
    rd_chk = 1'b1;
    @(posedge clk_sys_i) #1;
    rd_chk = 1'b0;
  endtask
  // bounded wait for the scoreboard to empty; a hang ends the run
  task automatic drain();
    for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge clk_sys_i);
    if (exp_q.size() > 0) begin
      err_total++;
      end_of_test();
    end
  endtask
  // tuning for both channels first, then offsets, then the sync toggle;
  // st is the step the channel 0 accumulator must take in its mode
  task automatic sync_check(input logic [11:0] freq_tuning_word, input logic [11:0] p,
                            input logic [11:0] st);
    wr12(C0 + 12'h004, freq_tuning_word);
    wr12(C1 + 12'h004, freq_tuning_word);
    wr12(C0 + 12'h006, p);
    wr12(C1 + 12'h006, ~p);
    sync_bit = ~sync_bit;
    wr(SY, {3'b000, sync_bit, 4'h0});
    reg_addr_i = C0 + ddc_pkg::ACC_RD_OFS;
    kind = 1;
    // offset lands at the first edge after the write, read one edge later
    @(posedge clk_sys_i);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys_i) #1;
      acc = 12'(p + st * k);
      exp_q.push_back({24'h0, acc[11:4]});
      rd_chk = 1'b1;
    end
    @(posedge clk_sys_i) #1;
    rd_chk = 1'b0;
  endtask
  task automatic rate(input int r);
    wr(C0, r[7:0]);
    wr(C1, 8'h08 | (8'd3 - r[7:0]));
    for (int c = 0; c < 2; c++) begin
      kind = 0;
      ch = c;
      repeat (60) @(posedge clk_sys_i);
      #1 kind = 2;
      repeat (2) exp_q.push_back(c == 0 ? 2 << r : 1 << (3 - r));
      drain();
    end
    kind = 0;
  endtask
  // steady input through both channels; x is the settled output word
  task automatic flat(input logic [7:0] ctl, input logic [31:0] x, input int n);
    wr(C0, ctl);
    wr(C1, ctl);
    for (int c = 0; c < n; c++) begin
      kind = 0;
      ch = c;
      repeat (60) @(posedge clk_sys_i);
      #1 kind = 3;
      repeat (3) exp_q.push_back(x);
      drain();
    end
    kind = 0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(8));
    repeat (10) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    rd(SY, 8'h00);
    rd(C0, 8'h00);
    rd(C1, 8'h00);
    rd(ddc_pkg::SYSREF_CTL_ADDR, 8'h00);
    pw = 12'($urandom);
    wr(C1, pw[7:0]);
    rd(C1, pw[7:0]);
    wr(12'h3ff, pw[7:0]);
    rd(12'h3ff, 8'h00);
    wr(C0, 8'h00);
    wr(C1, 8'h00);
    $display("test registers done");
    // awkward steps: wrap through minus half rate and the top code
    sync_check(12'h100, 12'($urandom), 12'h100);
    sync_check(12'h800, 12'($urandom), 12'h800);
    sync_check(12'h7ff, 12'($urandom), 12'h7ff);
    pw = 12'($urandom);
    sync_check(pw, 12'($urandom), pw);
    // fs/4 mode steps by a quarter turn whatever the tuning word says
    wr(C0, 8'h20);
    wr(C1, 8'h20);
    sync_check(12'h123, 12'($urandom), ddc_pkg::FS4_STEP);
    wr(C0, 8'h00);
    wr(C1, 8'h00);
    $display("test soft sync done");
    pw = 12'($urandom);
    sync_check(12'h000, pw, 12'h000);
    wr12(C0 + 12'h006, ~pw ^ 12'h5a0);
    wr12(C1 + 12'h006, pw ^ 12'h5a0);
    // a sysref with the enables clear must leave the phase alone
    @(posedge clk_sys_i) #1 sysref_i = 1'b1;
    repeat (4) @(posedge clk_sys_i) #1 sysref_i = 1'b0;
    rd(C0 + ddc_pkg::ACC_RD_OFS, pw[11:4]);
    wr(ddc_pkg::SYSREF_CTL_ADDR, 8'h02);
    wr(SY, {3'b000, sync_bit, 4'h1});
    @(posedge clk_sys_i) #1 sysref_i = 1'b1;
    repeat (4) @(posedge clk_sys_i) #1 sysref_i = 1'b0;
    acc = ~pw ^ 12'h5a0;
    rd(C0 + ddc_pkg::ACC_RD_OFS, acc[11:4]);
    acc = pw ^ 12'h5a0;
    rd(C1 + ddc_pkg::ACC_RD_OFS, acc[11:4]);
    wr(ddc_pkg::SYSREF_CTL_ADDR, 8'h00);
    $display("test sysref sync done");
    for (int r = 0; r < 4; r++) rate(r);
    $display("test decimation rates done");
    @(posedge clk_sys_i) #1 lvl_i = 12'($urandom);
    lvl_q = 12'($urandom);
    flat(8'h11, {lvl_i, 4'h0, 16'h0000}, 2);
    flat(8'h90, {lvl_i, 4'h0, lvl_q, 4'h0}, 2);
    $display("test zero if done");
    // 0.999 fs against a full-scale cosine at phase zero, no sine part
    sync_check(12'h000, 12'h000, 12'h000);
    flat(8'h30, 32'h7fd0_0000, 1);
    $display("test forced input done");
    end_of_test();
  end
endmodule
`default_nettype wire
